// ==== slic_map.vh ====
// Purpose: Shared constants of the status LED indicator controller.
// Assumes: 125 MHz system clock.
// Notes:   Definitions only; included by its bare name.
`ifndef SLIC_MAP_VH
`define SLIC_MAP_VH

// Clock rate in kHz, so that ms times times this give cycles
`define SLIC_CLK_KHZ       125000
// Fast blink half period in ms
`define SLIC_FAST_HALF_MS  125
// Flash on time in ms
`define SLIC_FLASH_MS      20
// Derived cycle counts
`define SLIC_FAST_HALF_CYC (`SLIC_FAST_HALF_MS * `SLIC_CLK_KHZ)
`define SLIC_FLASH_CYC     (`SLIC_FLASH_MS * `SLIC_CLK_KHZ)
// Slow half period is this many fast half periods, minus one
`define SLIC_SLOW_RATIO_M1 2'h3

// Channel count and colours per LED
`define SLIC_NUM_CH        1
`define SLIC_COLOURS       2

// Counter width and its constants
`define SLIC_CNT_W         32
`define SLIC_CNT_ZERO      32'h0
`define SLIC_CNT_ONE       32'h1

// Running sequence positions
`define SLIC_RUN_PWR_G     4'h0
`define SLIC_RUN_PWR_Y     4'h1
`define SLIC_RUN_TRF0      4'h2
`define SLIC_RUN_ONE       4'h1

// LED pattern codes; colour A is green (power) or yellow (traffic)
`define SLIC_PAT_OFF       4'h0
`define SLIC_PAT_ON_A      4'h1
`define SLIC_PAT_ON_B      4'h2
`define SLIC_PAT_SBLINK_A  4'h3
`define SLIC_PAT_SBLINK_B  4'h4
`define SLIC_PAT_FBLINK_A  4'h5
`define SLIC_PAT_FBLINK_B  4'h6
`define SLIC_PAT_SWAVER    4'h7
`define SLIC_PAT_FWAVER    4'h8

`endif

// ==== slic_flash.v ====
// Purpose: Retriggerable pulse stretcher for one LED colour flash.
// Assumes: trig is a one-cycle event on sys_clk.
// Notes:   A new event reloads the count, so close events merge.
`timescale 1ns/100ps
`include "slic_map.vh"

module slic_flash #(
    parameter [`SLIC_CNT_W-1:0] FLASH_CYC = `SLIC_FLASH_CYC
) (
    // Clock, reset, enable
    input  wire sys_clk,
    input  wire rst_b,
    input  wire clk_en,
    // Event in
    input  wire trig,
    // Stretched flash out
    output wire lit
);

    reg [`SLIC_CNT_W-1:0] cnt_q; // Remaining on time

    // Load on event, else count down to zero
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= `SLIC_CNT_ZERO;
        end else if (clk_en) begin
            if (trig) begin
                // Reload wins over expiry
                cnt_q <= FLASH_CYC;
            end else if (cnt_q != `SLIC_CNT_ZERO) begin
                cnt_q <= cnt_q - `SLIC_CNT_ONE;
            end
        end
    end

    // Lit while time remains
    assign lit = (cnt_q != `SLIC_CNT_ZERO);

endmodule

// ==== slic_ctrl.v ====
// Purpose: Status LED indicator controller: power LED and per channel
//          traffic LED patterns from device and bus status.
// Assumes: All status inputs come from logic on sys_clk; events are
//          one-cycle pulses.
// Notes:   LED outputs are registered and active high.
// Notes on behaviour
// - Slow blink has equal on and off
// - Fast blink is equal duty, faster
// - Flash is short pulse; repeats merge
// - Slow waver swaps colours at slow rate
// - Fast waver swaps colours at fast rate
// - Running lights each colour in turn
// - Configured and healthy: power steady green
// - Unconfigured: power slow yellow, traffic off
// - Config fault: power and traffic slow waver
// - Low supply: power waver, traffic slow yellow
// - Idle channel keeps traffic LED off
// - Yellow flash per frame, red per error
// - Firmware update fast blinks all traffic yellow
// - Error passive fast blinks traffic red
// - Overrun holds red until bus off
// - Device error lights all traffic red
// - Running script may override any LED
// - One traffic LED per channel
`timescale 1ns/100ps
`include "slic_map.vh"

module slic_ctrl #(
    parameter [`SLIC_CNT_W-1:0] FAST_HALF_CYC = `SLIC_FAST_HALF_CYC,
    parameter [`SLIC_CNT_W-1:0] FLASH_CYC     = `SLIC_FLASH_CYC
) (
    // Clock, reset, enable
    input  wire                        sys_clk,
    input  wire                        rst_b,
    input  wire                        clk_en,
    // Device status
    input  wire                        usb_configured,
    input  wire                        fw_update,
    input  wire                        fw_cfg_error,
    input  wire                        low_supply,
    input  wire                        device_error,
    input  wire                        run_pattern,
    // Per channel bus status
    input  wire [`SLIC_NUM_CH-1:0]     frame_event,
    input  wire [`SLIC_NUM_CH-1:0]     error_frame_event,
    input  wire [`SLIC_NUM_CH-1:0]     error_passive,
    input  wire [`SLIC_NUM_CH-1:0]     overrun_event,
    input  wire [`SLIC_NUM_CH-1:0]     bus_off,
    // Script override
    input  wire                        script_running,
    input  wire                        script_pwr_en,
    input  wire [3:0]                  script_pwr_pat,
    input  wire [`SLIC_NUM_CH-1:0]     script_trf_en,
    input  wire [4*`SLIC_NUM_CH-1:0]   script_trf_pat,
    // LED drive
    output wire                        power_indicator_green,
    output wire                        power_indicator_yellow,
    output wire [`SLIC_NUM_CH-1:0]     traffic_yellow,
    output wire [`SLIC_NUM_CH-1:0]     traffic_red,
    // Status readback
    output wire [`SLIC_NUM_CH-1:0]     overrun_held
);

    // Last running sequence position
    localparam [3:0] RUN_LAST = `SLIC_RUN_TRF0
                              + `SLIC_NUM_CH * `SLIC_COLOURS - `SLIC_RUN_ONE;

    // Divider state
    reg [`SLIC_CNT_W-1:0]  div_q;       // Cycles into fast half period
    reg                    fast_ph_q;   // Fast blink phase
    reg [1:0]              slow_cnt_q;  // Fast halves into slow half
    reg                    slow_ph_q;   // Slow blink phase
    reg [3:0]              run_q;       // Running sequence position

    // Channel state
    reg [`SLIC_NUM_CH-1:0] ovr_q;       // Overrun latch
    wire [`SLIC_NUM_CH-1:0] flash_y;    // Yellow flash active
    wire [`SLIC_NUM_CH-1:0] flash_r;    // Red flash active

    // Output registers and next values
    reg                    pwr_g_q;
    reg                    pwr_y_q;
    reg [`SLIC_NUM_CH-1:0] trf_y_q;
    reg [`SLIC_NUM_CH-1:0] trf_r_q;
    reg                    pwr_g_d;
    reg                    pwr_y_d;
    reg [`SLIC_NUM_CH-1:0] trf_y_d;
    reg [`SLIC_NUM_CH-1:0] trf_r_d;

    // End of a fast half period
    wire fast_end = (div_q == FAST_HALF_CYC - `SLIC_CNT_ONE);

    // Map a pattern code and phases to {colour B, colour A}
    function [1:0] pat_drive;
        input [3:0] pat;
        input       slow_ph;
        input       fast_ph;
        begin
            case (pat)
                `SLIC_PAT_OFF:      pat_drive = 2'h0;
                `SLIC_PAT_ON_A:     pat_drive = 2'h1;
                `SLIC_PAT_ON_B:     pat_drive = 2'h2;
                // Equal on and off halves
                `SLIC_PAT_SBLINK_A: pat_drive = {1'b0, slow_ph};
                `SLIC_PAT_SBLINK_B: pat_drive = {slow_ph, 1'b0};
                // Faster, still equal halves
                `SLIC_PAT_FBLINK_A: pat_drive = {1'b0, fast_ph};
                `SLIC_PAT_FBLINK_B: pat_drive = {fast_ph, 1'b0};
                // Second colour fills the off half
                `SLIC_PAT_SWAVER:   pat_drive = {~slow_ph, slow_ph};
                `SLIC_PAT_FWAVER:   pat_drive = {~fast_ph, fast_ph};
                // Unknown codes stay dark
                default:            pat_drive = 2'h0;
            endcase
        end
    endfunction

    // Single free-running divider for all blink phases
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q      <= `SLIC_CNT_ZERO;
            fast_ph_q  <= 1'b0;
            slow_cnt_q <= 2'h0;
            slow_ph_q  <= 1'b0;
            run_q      <= `SLIC_RUN_PWR_G;
        end else if (clk_en) begin
            if (fast_end) begin
                // Fast phase flips each half period
                div_q     <= `SLIC_CNT_ZERO;
                fast_ph_q <= ~fast_ph_q;
                // Slow phase flips on a whole number of fast halves
                if (slow_cnt_q == `SLIC_SLOW_RATIO_M1) begin
                    slow_cnt_q <= 2'h0;
                    slow_ph_q  <= ~slow_ph_q;
                end else begin
                    slow_cnt_q <= slow_cnt_q + 2'h1;
                end
                // Running sequence steps at the fast rate
                if (run_q == RUN_LAST) begin
                    run_q <= `SLIC_RUN_PWR_G;
                end else begin
                    run_q <= run_q + `SLIC_RUN_ONE;
                end
            end else begin
                div_q <= div_q + `SLIC_CNT_ONE;
            end
        end
    end

    // Overrun latch per channel
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ovr_q <= {`SLIC_NUM_CH{1'b0}};
        end else if (clk_en) begin
            // Set wins over a bus off in the same cycle
            ovr_q <= overrun_event | (ovr_q & ~bus_off);
        end
    end

    assign overrun_held = ovr_q;

    // Flash stretchers, one pair per channel
    genvar gi;
    generate
        for (gi = 0; gi < `SLIC_NUM_CH; gi = gi + 1) begin : g_ch
            // Frame sent or received
            slic_flash #(
                .FLASH_CYC (FLASH_CYC)
            ) u_flash_y (
                .sys_clk (sys_clk),
                .rst_b   (rst_b),
                .clk_en  (clk_en),
                .trig    (frame_event[gi]),
                .lit     (flash_y[gi])
            );
            // Error frame received
            slic_flash #(
                .FLASH_CYC (FLASH_CYC)
            ) u_flash_r (
                .sys_clk (sys_clk),
                .rst_b   (rst_b),
                .clk_en  (clk_en),
                .trig    (error_frame_event[gi]),
                .lit     (flash_r[gi])
            );
        end
    endgenerate

    // Power LED selection
    always @* begin
        pwr_g_d = 1'b0;
        pwr_y_d = 1'b0;
        if (script_running && script_pwr_en) begin
            // Script pattern replaces the default
            {pwr_y_d, pwr_g_d} = pat_drive(script_pwr_pat,
                                           slow_ph_q, fast_ph_q);
        end else if (run_pattern) begin
            // One colour at a time
            pwr_g_d = (run_q == `SLIC_RUN_PWR_G);
            pwr_y_d = (run_q == `SLIC_RUN_PWR_Y);
        end else if (fw_cfg_error) begin
            {pwr_y_d, pwr_g_d} = pat_drive(`SLIC_PAT_SWAVER,
                                           slow_ph_q, fast_ph_q);
        end else if (low_supply) begin
            {pwr_y_d, pwr_g_d} = pat_drive(`SLIC_PAT_SWAVER,
                                           slow_ph_q, fast_ph_q);
        end else if (!usb_configured) begin
            {pwr_y_d, pwr_g_d} = pat_drive(`SLIC_PAT_SBLINK_B,
                                           slow_ph_q, fast_ph_q);
        end else begin
            // Healthy and configured
            pwr_g_d = 1'b1;
        end
    end

    // Traffic LED selection, one per channel
    integer ch;
    always @* begin
        trf_y_d = {`SLIC_NUM_CH{1'b0}};
        trf_r_d = {`SLIC_NUM_CH{1'b0}};
        for (ch = 0; ch < `SLIC_NUM_CH; ch = ch + 1) begin
            if (script_running && script_trf_en[ch]) begin
                // Script has first claim
                {trf_r_d[ch], trf_y_d[ch]} = pat_drive(script_trf_pat[4*ch +: 4],
                                                       slow_ph_q, fast_ph_q);
            end else if (run_pattern) begin
                // Yellow then red of each channel in turn
                trf_y_d[ch] = (run_q == `SLIC_RUN_TRF0 + ch[3:0] * 4'h2);
                trf_r_d[ch] = (run_q == `SLIC_RUN_TRF0 + ch[3:0] * 4'h2
                                        + `SLIC_RUN_ONE);
            end else if (fw_update) begin
                // All channels together, same phase
                {trf_r_d[ch], trf_y_d[ch]} = pat_drive(`SLIC_PAT_FBLINK_A,
                                                       slow_ph_q, fast_ph_q);
            end else if (fw_cfg_error) begin
                {trf_r_d[ch], trf_y_d[ch]} = pat_drive(`SLIC_PAT_SWAVER,
                                                       slow_ph_q, fast_ph_q);
            end else if (low_supply) begin
                {trf_r_d[ch], trf_y_d[ch]} = pat_drive(`SLIC_PAT_SBLINK_A,
                                                       slow_ph_q, fast_ph_q);
            end else if (!usb_configured) begin
                // Dark until configured
                trf_y_d[ch] = 1'b0;
            end else if (device_error) begin
                // All red together
                trf_r_d[ch] = 1'b1;
            end else if (ovr_q[ch]) begin
                // Held red, traffic cannot clear it
                trf_r_d[ch] = 1'b1;
            end else if (error_passive[ch]) begin
                {trf_r_d[ch], trf_y_d[ch]} = pat_drive(`SLIC_PAT_FBLINK_B,
                                                       slow_ph_q, fast_ph_q);
            end else if (flash_y[ch] || flash_r[ch]) begin
                // Event flashes
                trf_y_d[ch] = flash_y[ch];
                trf_r_d[ch] = flash_r[ch];
            end else begin
                // Idle bus
                trf_y_d[ch] = 1'b0;
            end
        end
    end

    // LED output registers
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pwr_g_q <= 1'b0;
            pwr_y_q <= 1'b0;
            trf_y_q <= {`SLIC_NUM_CH{1'b0}};
            trf_r_q <= {`SLIC_NUM_CH{1'b0}};
        end else if (clk_en) begin
            pwr_g_q <= pwr_g_d;
            pwr_y_q <= pwr_y_d;
            trf_y_q <= trf_y_d;
            trf_r_q <= trf_r_d;
        end
    end

    // Drive pins from registers
    assign power_indicator_green  = pwr_g_q;
    assign power_indicator_yellow = pwr_y_q;
    assign traffic_yellow         = trf_y_q;
    assign traffic_red            = trf_r_q;

endmodule

// ==== slic_led_model.sv ====
// Purpose: Dual-colour indicator LED seen by the eye, as run lengths.
// Assumes: col_a and col_b are the two colour drives, high = lit.
// Notes:   Reports the last two complete runs of one colour state.
`timescale 1ns/100ps

module slic_led_model (
    // Clock and reset
    input  wire sys_clk,
    input  wire rst_b,
    // Colour drives
    input  wire col_a,
    input  wire col_b,
    // Lengths of the two latest runs
    output int  last_len,
    output int  prev_len
);
    logic [1:0] st_q;  // Colour state of the current run
    int         run_q; // Cycles spent in it so far

    // Close a run on every change of the lit colours
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= 2'h0;
            run_q <= 0;
            last_len <= 0;
            prev_len <= 0;
        end else if ({col_a, col_b} != st_q) begin
            prev_len <= last_len;
            last_len <= run_q;
            run_q <= 1;
            st_q <= {col_a, col_b};
        end else begin
            run_q <= run_q + 1;
        end
    end
endmodule

// ==== slic_ctrl_chk.sv ====
// Purpose: Port assertions for the status LED controller.
// Assumes: One clock domain; rst_b active low.
// Notes:   Bound to every slic_ctrl instance.
`timescale 1ns/100ps
`include "slic_map.vh"

module slic_ctrl_chk #(
    parameter [`SLIC_CNT_W-1:0] FAST_HALF_CYC = `SLIC_FAST_HALF_CYC,
    parameter [`SLIC_CNT_W-1:0] FLASH_CYC     = `SLIC_FLASH_CYC
) (
    // Clock, reset, enable
    input wire                    sys_clk,
    input wire                    rst_b,
    input wire                    clk_en,
    // Device status
    input wire                    usb_configured,
    input wire                    fw_update,
    input wire                    fw_cfg_error,
    input wire                    low_supply,
    input wire                    device_error,
    input wire                    run_pattern,
    input wire                    script_running,
    // Channel status
    input wire [`SLIC_NUM_CH-1:0] frame_event,
    input wire [`SLIC_NUM_CH-1:0] error_frame_event,
    input wire [`SLIC_NUM_CH-1:0] error_passive,
    input wire [`SLIC_NUM_CH-1:0] overrun_event,
    input wire [`SLIC_NUM_CH-1:0] bus_off,
    // LED drive
    input wire                    power_indicator_green,
    input wire                    power_indicator_yellow,
    input wire [`SLIC_NUM_CH-1:0] traffic_yellow,
    input wire [`SLIC_NUM_CH-1:0] traffic_red,
    input wire [`SLIC_NUM_CH-1:0] overrun_held
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // No device-wide pattern owns the power LED
    wire dev_calm = clk_en && !script_running && !run_pattern && !fw_cfg_error && !low_supply;
    // Only event flashes may light the traffic LED
    wire trf_calm = dev_calm && !fw_update && usb_configured && !device_error
                    && !overrun_held[0] && !overrun_event[0] && !error_passive[0];

    a_flash_yellow: assert property (frame_event[0] && trf_calm ##1 trf_calm |=> traffic_yellow[0])
        else $error("no yellow flash after frame");
    a_flash_red: assert property (error_frame_event[0] && trf_calm ##1 trf_calm |=> traffic_red[0])
        else $error("no red flash after error frame");
    a_overrun_set: assert property (clk_en && overrun_event[0] |=> overrun_held[0])
        else $error("overrun not latched");
    a_overrun_keep: assert property (clk_en && overrun_held[0] && !bus_off[0] |=> overrun_held[0])
        else $error("overrun latch lost");
    a_overrun_clear: assert property (clk_en && bus_off[0] && !overrun_event[0] |=> !overrun_held[0])
        else $error("bus off left overrun set");
    a_power_green: assert property (dev_calm && usb_configured |=>
                                    power_indicator_green && !power_indicator_yellow)
        else $error("power not steady green");
    a_unconf_dark: assert property (dev_calm && !fw_update && !usb_configured |=>
                                    !traffic_yellow[0] && !traffic_red[0])
        else $error("traffic lit while unconfigured");
    a_device_red: assert property (dev_calm && !fw_update && usb_configured && device_error |=>
                                   traffic_red[0] && !traffic_yellow[0])
        else $error("device error not red");
    a_one_colour: assert property (!(power_indicator_green && power_indicator_yellow))
        else $error("both power colours lit");
    a_frozen_out: assert property (!clk_en |=> $stable(power_indicator_green)
                                   && $stable(traffic_yellow) && $stable(traffic_red))
        else $error("outputs moved while disabled");
endmodule

bind slic_ctrl slic_ctrl_chk #(.FAST_HALF_CYC(FAST_HALF_CYC), .FLASH_CYC(FLASH_CYC)) i_chk (
    .sys_clk, .rst_b, .clk_en, .usb_configured, .fw_update, .fw_cfg_error, .low_supply,
    .device_error, .run_pattern, .script_running, .frame_event, .error_frame_event,
    .error_passive, .overrun_event, .bus_off, .power_indicator_green, .power_indicator_yellow,
    .traffic_yellow, .traffic_red, .overrun_held
);

// ==== tb_slic_ctrl.sv ====
// Purpose: Self-checking bench for the status LED controller.
// Assumes: Short blink counts; inputs driven on the falling edge.
// Notes:   Run lengths are measured by two LED models.
`timescale 1ns/100ps
`include "slic_map.vh"

module tb_slic_ctrl;
    localparam [`SLIC_CNT_W-1:0] FAST = 32'h8;
    localparam [`SLIC_CNT_W-1:0] FLASH = 32'h5;
    localparam int FAST_I = int'(FAST);
    localparam int SLOW_I = 4 * FAST_I;
    // Stimulus
    logic sys_clk, rst_b, clk_en, usb_configured, fw_update, fw_cfg_error;
    logic low_supply, device_error, run_pattern, script_running, script_pwr_en;
    logic [`SLIC_NUM_CH-1:0] frame_event, error_frame_event, error_passive, overrun_event;
    logic [`SLIC_NUM_CH-1:0] bus_off, script_trf_en;
    logic [3:0] script_pwr_pat;
    logic [4*`SLIC_NUM_CH-1:0] script_trf_pat;
    // LED outputs and their measured runs
    wire pwr_g, pwr_y;
    wire [`SLIC_NUM_CH-1:0] trf_y, trf_r, ovr_held;
    wire [3:0] run_vec = {pwr_g, pwr_y, trf_y[0], trf_r[0]};
    int pwr_last, pwr_prev, trf_last, trf_prev, n, k;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc_cnt = 0;
    logic [3:0] hold;

    slic_ctrl #(.FAST_HALF_CYC(FAST), .FLASH_CYC(FLASH)) i_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .usb_configured(usb_configured),
        .fw_update(fw_update), .fw_cfg_error(fw_cfg_error), .low_supply(low_supply),
        .device_error(device_error), .run_pattern(run_pattern), .frame_event(frame_event),
        .error_frame_event(error_frame_event), .error_passive(error_passive),
        .overrun_event(overrun_event), .bus_off(bus_off), .script_running(script_running),
        .script_pwr_en(script_pwr_en), .script_pwr_pat(script_pwr_pat),
        .script_trf_en(script_trf_en), .script_trf_pat(script_trf_pat),
        .power_indicator_green(pwr_g), .power_indicator_yellow(pwr_y),
        .traffic_yellow(trf_y), .traffic_red(trf_r), .overrun_held(ovr_held));
    slic_led_model i_pwr_led (.sys_clk(sys_clk), .rst_b(rst_b), .col_a(pwr_g), .col_b(pwr_y),
        .last_len(pwr_last), .prev_len(pwr_prev));
    slic_led_model i_trf_led (.sys_clk(sys_clk), .rst_b(rst_b), .col_a(trf_r[0]),
        .col_b(trf_y[0]), .last_len(trf_last), .prev_len(trf_prev));

    // 125 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Hang guard
    always @(posedge sys_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 3000) begin
            error_cnt++;
            $display("[ERR] %0t timeout", $time);
            end_of_test();
        end
    end

    task automatic cyc(input int c);
        repeat (c) @(negedge sys_clk);
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s got %b", $time, what, got);
        end
    endtask
    task automatic chk_runs(input int last, input int prev, input int exp, input string what);
        comparisons++;
        if (last != exp || prev != exp) begin
            error_cnt++;
            $display("[ERR] %0t %s runs %0d %0d", $time, what, last, prev);
        end
    endtask
    task automatic pulse(ref logic [`SLIC_NUM_CH-1:0] sig);
        sig = 1'b1;
        cyc(1);
        sig = 1'b0;
    endtask
    task end_of_test;
        if (error_cnt == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Main sequence
    initial begin
        {rst_b, usb_configured, fw_update, fw_cfg_error, low_supply, device_error} = 6'h00;
        {run_pattern, script_running, script_pwr_en, script_pwr_pat} = 7'h00;
        {frame_event, error_frame_event, error_passive, overrun_event, bus_off} = 5'h00;
        {script_trf_en, script_trf_pat} = 5'h00;
        clk_en = 1'b1;
        cyc(3);
        rst_b = 1'b1;
        cyc(110);
        chk_runs(pwr_last, pwr_prev, SLOW_I, "unconfigured blink");
        chk_bit(trf_y[0] | trf_r[0], 1'b0, "unconfigured traffic");
        usb_configured = 1'b1;
        cyc(2);
        chk_bit(pwr_g, 1'b1, "power green");
        chk_bit(trf_y[0] | trf_r[0], 1'b0, "idle traffic");
        pulse(frame_event);
        cyc(2);
        chk_bit(trf_y[0], 1'b1, "frame flash");
        cyc(int'(FLASH) + 4);
        chk_bit(trf_y[0], 1'b0, "flash end");
        for (k = 0; k < 8; k++) begin
            frame_event = (k % 2 == 0);
            cyc(1);
            if (k > 2) chk_bit(trf_y[0], 1'b1, "merged flashes");
        end
        frame_event = 1'b0;
        cyc(10);
        pulse(error_frame_event);
        cyc(2);
        chk_bit(trf_r[0], 1'b1, "error flash");
        cyc(10);
        error_passive = 1'b1;
        cyc(40);
        chk_runs(trf_last, trf_prev, FAST_I, "passive blink");
        error_passive = 1'b0;
        pulse(overrun_event);
        cyc(2);
        chk_bit(trf_r[0] & ovr_held[0], 1'b1, "overrun red");
        pulse(frame_event);
        cyc(10);
        chk_bit(trf_r[0] & ~trf_y[0], 1'b1, "overrun kept");
        fw_update = 1'b1;
        cyc(40);
        chk_runs(trf_last, trf_prev, FAST_I, "update blink");
        chk_bit(trf_r[0], 1'b0, "update over overrun");
        fw_update = 1'b0;
        pulse(bus_off);
        cyc(2);
        chk_bit(trf_r[0] | ovr_held[0], 1'b0, "bus off clears");
        fw_cfg_error = 1'b1;
        cyc(110);
        chk_runs(pwr_last, pwr_prev, SLOW_I, "config power waver");
        chk_runs(trf_last, trf_prev, SLOW_I, "config traffic waver");
        chk_bit(trf_y[0] | trf_r[0], 1'b1, "waver never dark");
        fw_cfg_error = 1'b0;
        low_supply = 1'b1;
        cyc(110);
        chk_runs(pwr_last, pwr_prev, SLOW_I, "supply power waver");
        chk_runs(trf_last, trf_prev, SLOW_I, "supply traffic blink");
        chk_bit(pwr_g | pwr_y, 1'b1, "supply waver lit");
        low_supply = 1'b0;
        device_error = 1'b1;
        cyc(2);
        chk_bit(trf_r[0] & ~trf_y[0], 1'b1, "device error red");
        {script_running, script_trf_en, script_pwr_en} = 3'h7;
        for (k = 0; k < 3; k++) begin
            script_pwr_pat = k[3:0];
            cyc(2);
            chk_bit({pwr_g, pwr_y} === ((k == 0) ? 2'b00 : (k == 1) ? 2'b10 : 2'b01), 1'b1,
                    "script power");
        end
        chk_bit(trf_r[0], 1'b0, "script over error");
        script_pwr_pat = `SLIC_PAT_FWAVER;
        cyc(40);
        chk_runs(pwr_last, pwr_prev, FAST_I, "script waver");
        {script_running, script_trf_en, script_pwr_en, device_error} = 4'h0;
        run_pattern = 1'b1;
        // Let the waver output drain before hunting for the green step
        cyc(2);
        n = 0;
        while (pwr_g !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        while (pwr_g === 1'b1 && n < 80) begin
            cyc(1);
            n++;
        end
        cyc(4);
        for (k = 1; k < 5; k++) begin
            chk_bit(run_vec === (4'h8 >> (k % 4)), 1'b1, "running step");
            cyc(FAST_I);
        end
        clk_en = 1'b0;
        hold = run_vec;
        cyc(20);
        chk_bit(run_vec === hold, 1'b1, "frozen");
        clk_en = 1'b1;
        end_of_test();
    end
endmodule
